// ===== core/dioc_pkg.sv
/*
 * Shared constants of the digital I/O channel logic: object indices,
 * subindices, reset values, frame identifier bases and timing counts.
 * Assumes a single module clock of 25 MHz.
 */
package dioc_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int NUM_IN  = 16;
   localparam int NUM_OUT = 8;

   // ----------------------------------------------------------------
   // Object indices
   // ----------------------------------------------------------------
   localparam logic [15:0] IDX_INPUTS      = 16'h6000;
   localparam logic [15:0] IDX_FILTER_EN   = 16'h6003;
   localparam logic [15:0] IDX_GLOBAL_EN   = 16'h6005;
   localparam logic [15:0] IDX_ANY_MASK    = 16'h6006;
   localparam logic [15:0] IDX_RISE_MASK   = 16'h6007;
   localparam logic [15:0] IDX_FALL_MASK   = 16'h6008;
   localparam logic [15:0] IDX_OUTPUTS     = 16'h6200;
   localparam logic [15:0] IDX_ERR_MODE    = 16'h6206;
   localparam logic [15:0] IDX_ERR_VALUE   = 16'h6207;
   localparam logic [15:0] IDX_UPDATE_GATE = 16'h6208;
   localparam logic [15:0] IDX_PULSE_EN    = 16'h2011;
   localparam logic [15:0] IDX_RETRIG_EN   = 16'h2012;
   localparam logic [15:0] IDX_EARLY_OFF   = 16'h2013;
   localparam logic [15:0] IDX_PULSE_LEN   = 16'h2014;

   // ----------------------------------------------------------------
   // Subindices
   // ----------------------------------------------------------------
   localparam logic [7:0] SUB_VAR  = 8'h00;
   localparam logic [7:0] SUB_LOW  = 8'h01;
   localparam logic [7:0] SUB_HIGH = 8'h02;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_RISE_MASK   = 8'h00;
   localparam logic [7:0] RST_FALL_MASK   = 8'h00;
   localparam logic [7:0] RST_ANY_MASK    = 8'hFF;
   localparam logic       RST_GLOBAL_EN   = 1'b0;
   localparam logic [7:0] RST_FILTER_EN   = 8'h00;
   localparam logic [7:0] RST_ERR_MODE    = 8'h00;
   localparam logic [7:0] RST_ERR_VALUE   = 8'h00;
   localparam logic [7:0] RST_UPDATE_GATE = 8'hFF;
   localparam logic [7:0] RST_PULSE_EN    = 8'h00;
   localparam logic [7:0] RST_RETRIG_EN   = 8'h00;
   localparam logic [7:0] RST_EARLY_OFF   = 8'h00;
   localparam logic [7:0] RST_PULSE_LEN   = 8'h01;

   // ----------------------------------------------------------------
   // Frame identifiers
   // ----------------------------------------------------------------
   localparam logic [10:0] COB_TX_BASE = 11'h180;
   localparam logic [10:0] COB_RX_BASE = 11'h200;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 40;
   localparam int PULSE_UNIT_NS   = 1000000;
   localparam int MS_CYCLES_DEF   = PULSE_UNIT_NS / CLK_PERIOD_NS;
   localparam int FILT_CYCLES_DEF = 8;

endpackage

// ===== core/dioc_pulse_channel.sv
/*
 * One output channel: plain level or millisecond pulse with retrigger,
 * early switch-off and error substitution.
 * Assumes load and err_force are single-cycle strobes from the same clock.
 */
`timescale 1ns/1ns
module dioc_pulse_channel
   import dioc_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYCLES_DEF
)(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       pulse_en,
   input  wire logic       retrig_en,
   input  wire logic       early_off_en,
   input  wire logic [7:0] len_ms,
   input  wire logic       load,
   input  wire logic       on_cmd,
   input  wire logic       err_force,
   input  wire logic       err_val,
   output logic            out_q
);
   localparam int CW = $clog2(MS_CYCLES + 1);
   localparam logic [CW-1:0] CYC_LAST = CW'(MS_CYCLES - 1);

   logic          out_d;
   logic [7:0]    cnt_q, cnt_d;
   logic [CW-1:0] cyc_q, cyc_d;

   always_comb begin
      out_d = out_q;
      cnt_d = cnt_q;
      cyc_d = cyc_q;
      if (err_force) begin
         out_d = err_val;
         cnt_d = (err_val && pulse_en) ? len_ms : 8'h00;
         cyc_d = '0;
      end else if (load) begin
         if (!pulse_en) begin
            out_d = on_cmd;
         end else if (on_cmd && (!out_q || retrig_en)) begin
            out_d = 1'b1;
            cnt_d = len_ms;
            cyc_d = '0;
         end else if (!on_cmd && out_q && early_off_en) begin
            out_d = 1'b0;
            cnt_d = 8'h00;
         end
      end else if (pulse_en && out_q) begin
         if (cyc_q == CYC_LAST) begin
            cyc_d = '0;
            if (cnt_q <= 8'h01) begin
               out_d = 1'b0;
               cnt_d = 8'h00;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end else begin
            cyc_d = cyc_q + CW'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out_q <= 1'b0;
         cnt_q <= 8'h00;
         cyc_q <= '0;
      end else begin
         out_q <= out_d;
         cnt_q <= cnt_d;
         cyc_q <= cyc_d;
      end
   end

   AST_LEVEL_MODE: assert property (@(posedge clk) disable iff (!resetn)
      (!pulse_en && load && !err_force) |=> out_q == $past(on_cmd))
      else $error("Level output did not follow command.");

   AST_RETRIGGER: assert property (@(posedge clk) disable iff (!resetn)
      (pulse_en && out_q && load && on_cmd && retrig_en && !err_force)
      |=> (cnt_q == $past(len_ms)) && (cyc_q == '0))
      else $error("Retrigger did not restart pulse timer.");

   AST_EARLY_OFF: assert property (@(posedge clk) disable iff (!resetn)
      (pulse_en && out_q && load && !on_cmd && !err_force)
      |=> (out_q == !$past(early_off_en)))
      else $error("Off command handled wrongly for pulse.");

   AST_PULSE_END: assert property (@(posedge clk) disable iff (!resetn)
      ($fell(out_q) && pulse_en && $past(!load && !err_force))
      |-> ($past(cnt_q) <= 8'h01) && ($past(cyc_q) == CYC_LAST))
      else $error("Pulse ended before its length.");

   AST_ERR_SUBST: assert property (@(posedge clk) disable iff (!resetn)
      err_force |=> out_q == $past(err_val))
      else $error("Error value not applied.");

endmodule

// ===== core/dioc_top.sv
/*
 * Channel logic of a digital I/O node: input filtering and edge events,
 * output update gating, error substitution and pulsed outputs, with the
 * configuration objects reached over an object index/subindex port.
 * Assumes the protocol stack delivers received frames and error events
 * as one-cycle strobes on clk and drains the transmit request.
 */
`timescale 1ns/1ns

// What this block does
// - Rising edge on a line with rising mask bit set raises an input event.
// - Falling edge on a line with falling mask bit set raises an input event.
// - On error event, outputs with error-mode bit set take their error value.
// - Error value bit 0 drives output low, bit 1 drives it high.
// - Update-gate bit 0 keeps the output; bit 1 loads received data.
// - Pulse-enable bit makes turn-on a self-ending pulse; else plain level.
// - With retrigger, a new turn-on during a pulse restarts its timer.
// - With early switch-off, an off command ends the pulse at once.
// - Pulse length is counted in milliseconds; reset length is one.
// - Input events occur only while the global event enable is set.
// - Inputs go out as two bytes at 180H+node; outputs come at 200H+node.
// - The input filter acts only on lines whose filter enable is set.
// - Any-change mask bit set raises an event on either edge.
// - Global enable gates events without touching masks; resets disabled.
module dioc_top
   import dioc_pkg::*;
#(
   parameter int MS_CYCLES   = MS_CYCLES_DEF,
   parameter int FILT_CYCLES = FILT_CYCLES_DEF
)(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic [NUM_IN-1:0] in_pins,
   input  wire logic [6:0]        node_id,
   input  wire logic              rx_valid,
   input  wire logic [10:0]       rx_cob_id,
   input  wire logic [7:0]        rx_byte,
   input  wire logic              error_event,
   input  wire logic              obj_wr,
   input  wire logic              obj_rd,
   input  wire logic [15:0]       obj_index,
   input  wire logic [7:0]        obj_subindex,
   input  wire logic [7:0]        obj_wdata,
   output logic [7:0]             obj_rdata_q,
   output logic                   obj_ack_q,
   output logic                   obj_err_q,
   output logic                   tx_request_q,
   output logic [10:0]            tx_cob_id_q,
   output logic [7:0]             input_byte_low,
   output logic [7:0]             input_byte_high,
   output logic [NUM_OUT-1:0]     output_byte
);
   localparam int FW = $clog2(FILT_CYCLES + 1);
   localparam logic [FW-1:0] FILT_LAST = FW'(FILT_CYCLES - 1);

   // ----------------------------------------------------------------
   // Configuration objects
   // ----------------------------------------------------------------
   logic [NUM_IN-1:0]  rise_mask_q, rise_mask_d;
   logic [NUM_IN-1:0]  fall_mask_q, fall_mask_d;
   logic [NUM_IN-1:0]  any_mask_q, any_mask_d;
   logic [NUM_IN-1:0]  filt_en_q, filt_en_d;
   logic               glob_en_q, glob_en_d;
   logic [NUM_OUT-1:0] err_mode_q, err_mode_d;
   logic [NUM_OUT-1:0] err_val_q, err_val_d;
   logic [NUM_OUT-1:0] gate_q, gate_d;
   logic [NUM_OUT-1:0] pulse_en_q, pulse_en_d;
   logic [NUM_OUT-1:0] retrig_q, retrig_d;
   logic [NUM_OUT-1:0] early_off_q, early_off_d;
   logic [7:0]         len_q [NUM_OUT];
   logic [7:0]         len_d [NUM_OUT];
   logic [7:0]         rdata_d;
   logic               ack_d, err_d;
   logic               hit;

   always_comb begin
      rise_mask_d = rise_mask_q;
      fall_mask_d = fall_mask_q;
      any_mask_d  = any_mask_q;
      filt_en_d   = filt_en_q;
      glob_en_d   = glob_en_q;
      err_mode_d  = err_mode_q;
      err_val_d   = err_val_q;
      gate_d      = gate_q;
      pulse_en_d  = pulse_en_q;
      retrig_d    = retrig_q;
      early_off_d = early_off_q;
      len_d       = len_q;
      rdata_d     = obj_rdata_q;
      hit         = 1'b1;
      case (obj_index)
         IDX_INPUTS: begin
            case (obj_subindex)
               SUB_LOW:  rdata_d = input_byte_low;
               SUB_HIGH: rdata_d = input_byte_high;
               default:  hit = 1'b0;
            endcase
            // The input image is read-only, so a write is answered with an error.
            if (obj_wr) begin
               hit = 1'b0;
            end
         end
         IDX_FILTER_EN, IDX_ANY_MASK, IDX_RISE_MASK, IDX_FALL_MASK:
            if (obj_subindex == SUB_LOW || obj_subindex == SUB_HIGH) begin
               if (obj_subindex == SUB_LOW) begin
                  rdata_d = obj_index == IDX_FILTER_EN ? filt_en_q[7:0] :
                            obj_index == IDX_ANY_MASK  ? any_mask_q[7:0] :
                            obj_index == IDX_RISE_MASK ? rise_mask_q[7:0] :
                                                         fall_mask_q[7:0];
               end else begin
                  rdata_d = obj_index == IDX_FILTER_EN ? filt_en_q[15:8] :
                            obj_index == IDX_ANY_MASK  ? any_mask_q[15:8] :
                            obj_index == IDX_RISE_MASK ? rise_mask_q[15:8] :
                                                         fall_mask_q[15:8];
               end
               if (obj_wr) begin
                  case (obj_index)
                     IDX_FILTER_EN: filt_en_d[obj_subindex[1]*8 +: 8]   = obj_wdata;
                     IDX_ANY_MASK:  any_mask_d[obj_subindex[1]*8 +: 8]  = obj_wdata;
                     IDX_RISE_MASK: rise_mask_d[obj_subindex[1]*8 +: 8] = obj_wdata;
                     default:       fall_mask_d[obj_subindex[1]*8 +: 8] = obj_wdata;
                  endcase
               end
            end else begin
               hit = 1'b0;
            end
         IDX_GLOBAL_EN:
            if (obj_subindex == SUB_VAR) begin
               rdata_d = {7'h00, glob_en_q};
               if (obj_wr) begin
                  glob_en_d = obj_wdata[0];
               end
            end else begin
               hit = 1'b0;
            end
         IDX_OUTPUTS, IDX_ERR_MODE, IDX_ERR_VALUE, IDX_UPDATE_GATE,
         IDX_PULSE_EN, IDX_RETRIG_EN, IDX_EARLY_OFF:
            if (obj_subindex == SUB_LOW) begin
               case (obj_index)
                  IDX_OUTPUTS:     rdata_d = output_byte;
                  IDX_ERR_MODE:    rdata_d = err_mode_q;
                  IDX_ERR_VALUE:   rdata_d = err_val_q;
                  IDX_UPDATE_GATE: rdata_d = gate_q;
                  IDX_PULSE_EN:    rdata_d = pulse_en_q;
                  IDX_RETRIG_EN:   rdata_d = retrig_q;
                  default:         rdata_d = early_off_q;
               endcase
               if (obj_wr) begin
                  case (obj_index)
                     IDX_ERR_MODE:    err_mode_d  = obj_wdata;
                     IDX_ERR_VALUE:   err_val_d   = obj_wdata;
                     IDX_UPDATE_GATE: gate_d      = obj_wdata;
                     IDX_PULSE_EN:    pulse_en_d  = obj_wdata;
                     IDX_RETRIG_EN:   retrig_d    = obj_wdata;
                     IDX_EARLY_OFF:   early_off_d = obj_wdata;
                     default:         hit = 1'b0;
                  endcase
               end
            end else begin
               hit = 1'b0;
            end
         IDX_PULSE_LEN:
            if (obj_subindex >= 8'h01 && obj_subindex <= 8'(NUM_OUT)) begin
               rdata_d = len_q[3'(obj_subindex - 8'h01)];
               if (obj_wr) begin
                  len_d[3'(obj_subindex - 8'h01)] = obj_wdata;
               end
            end else begin
               hit = 1'b0;
            end
         default:
            hit = 1'b0;
      endcase
      if (!hit) begin
         rdata_d = 8'h00;
      end
      ack_d = obj_wr | obj_rd;
      err_d = (obj_wr | obj_rd) & ~hit;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rise_mask_q <= {2{RST_RISE_MASK}};
         fall_mask_q <= {2{RST_FALL_MASK}};
         any_mask_q  <= {2{RST_ANY_MASK}};
         filt_en_q   <= {2{RST_FILTER_EN}};
         glob_en_q   <= RST_GLOBAL_EN;
         err_mode_q  <= RST_ERR_MODE;
         err_val_q   <= RST_ERR_VALUE;
         gate_q      <= RST_UPDATE_GATE;
         pulse_en_q  <= RST_PULSE_EN;
         retrig_q    <= RST_RETRIG_EN;
         early_off_q <= RST_EARLY_OFF;
         len_q       <= '{default: RST_PULSE_LEN};
         obj_rdata_q <= 8'h00;
         obj_ack_q   <= 1'b0;
         obj_err_q   <= 1'b0;
      end else begin
         rise_mask_q <= rise_mask_d;
         fall_mask_q <= fall_mask_d;
         any_mask_q  <= any_mask_d;
         filt_en_q   <= filt_en_d;
         glob_en_q   <= glob_en_d;
         err_mode_q  <= err_mode_d;
         err_val_q   <= err_val_d;
         gate_q      <= gate_d;
         pulse_en_q  <= pulse_en_d;
         retrig_q    <= retrig_d;
         early_off_q <= early_off_d;
         len_q       <= len_d;
         obj_rdata_q <= rdata_d;
         obj_ack_q   <= ack_d;
         obj_err_q   <= err_d;
      end
   end

   // ----------------------------------------------------------------
   // Input sampling, filter and edge events
   // ----------------------------------------------------------------
   // The filter is a plain stability count; a line must hold its level for
   // FILT_CYCLES agreed samples, which trades latency for glitch immunity.
   logic [NUM_IN-1:0] s1_q, s2_q, s3_q;
   logic [NUM_IN-1:0] filt_q, filt_d, prev_q;
   logic [FW-1:0]     fcnt_q [NUM_IN];
   logic [FW-1:0]     fcnt_d [NUM_IN];
   logic [NUM_IN-1:0] rise, fall;
   logic              ev_d, in_event_q;

   for (genvar i = 0; i < NUM_IN; i++) begin : g_in
      always_comb begin
         filt_d[i] = filt_q[i];
         fcnt_d[i] = '0;
         if (s2_q[i] == s3_q[i] && s3_q[i] != filt_q[i]) begin
            if (!filt_en_q[i] || fcnt_q[i] == FILT_LAST) begin
               filt_d[i] = s3_q[i];
            end else begin
               fcnt_d[i] = fcnt_q[i] + FW'(1);
            end
         end
      end
   end

   assign rise = filt_q & ~prev_q;
   assign fall = ~filt_q & prev_q;

   always_comb begin
      ev_d = glob_en_q &
             (|(rise & (rise_mask_q | any_mask_q)) |
              |(fall & (fall_mask_q | any_mask_q)));
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_q       <= '0;
         s2_q       <= '0;
         s3_q       <= '0;
         filt_q     <= '0;
         prev_q     <= '0;
         fcnt_q     <= '{default: '0};
         in_event_q <= 1'b0;
      end else begin
         s1_q       <= in_pins;
         s2_q       <= s1_q;
         s3_q       <= s2_q;
         filt_q     <= filt_d;
         prev_q     <= filt_q;
         fcnt_q     <= fcnt_d;
         in_event_q <= ev_d;
      end
   end

   assign input_byte_low  = prev_q[7:0];
   assign input_byte_high = prev_q[15:8];

   // ----------------------------------------------------------------
   // Frame identifiers
   // ----------------------------------------------------------------
   logic        rx_hit;
   logic [10:0] tx_cob_d;

   assign rx_hit   = rx_valid && (rx_cob_id == COB_RX_BASE + {4'h0, node_id});
   assign tx_cob_d = COB_TX_BASE + {4'h0, node_id};

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_request_q <= 1'b0;
         tx_cob_id_q  <= COB_TX_BASE;
      end else begin
         tx_request_q <= in_event_q;
         tx_cob_id_q  <= tx_cob_d;
      end
   end

   // ----------------------------------------------------------------
   // Output channels
   // ----------------------------------------------------------------
   for (genvar k = 0; k < NUM_OUT; k++) begin : g_out
      dioc_pulse_channel #(
         .MS_CYCLES (MS_CYCLES)
      ) u_chan (
         .clk          (clk),
         .resetn       (resetn),
         .pulse_en     (pulse_en_q[k]),
         .retrig_en    (retrig_q[k]),
         .early_off_en (early_off_q[k]),
         .len_ms       (len_q[k]),
         .load         (rx_hit && gate_q[k]),
         .on_cmd       (rx_byte[k]),
         .err_force    (error_event && err_mode_q[k]),
         .err_val      (err_val_q[k]),
         .out_q        (output_byte[k])
      );
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_EVENT_GATED: assert property (@(posedge clk) disable iff (!resetn)
      in_event_q |-> $past(glob_en_q))
      else $error("Input event raised while globally disabled.");

   AST_RISE_EVENT: assert property (@(posedge clk) disable iff (!resetn)
      (glob_en_q && |(rise & rise_mask_q)) |=> in_event_q ##1 tx_request_q)
      else $error("Masked rising edge gave no event.");

   AST_FALL_EVENT: assert property (@(posedge clk) disable iff (!resetn)
      (glob_en_q && |(fall & fall_mask_q)) |=> in_event_q)
      else $error("Masked falling edge gave no event.");

   AST_ANY_EVENT: assert property (@(posedge clk) disable iff (!resetn)
      (glob_en_q && |((rise | fall) & any_mask_q)) |=> in_event_q)
      else $error("Any-change edge gave no event.");

   AST_GATE_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      (rx_hit && !error_event && pulse_en_q == 8'h00)
      |=> output_byte == (($past(output_byte) & ~$past(gate_q)) |
                          ($past(rx_byte) & $past(gate_q))))
      else $error("Output update gate not honoured.");

   AST_ERR_MODE: assert property (@(posedge clk) disable iff (!resetn)
      error_event |=> ((output_byte ^ $past(err_val_q)) & $past(err_mode_q)) == 8'h00)
      else $error("Error substitution missing.");

endmodule

// ===== sim/dioc_master_model.sv
/* Network master model: sends output frames and counts input frames.
   Assumes the bench calls send() and reads n_tx and last_id by hierarchy. */
`timescale 1ns/1ns
module dioc_master_model
   import dioc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic [6:0]  node_id,
   input  wire logic        tx_request_q,
   input  wire logic [10:0] tx_cob_id_q,
   output logic             rx_valid,
   output logic [10:0]      rx_cob_id,
   output logic [7:0]       rx_byte
);
   int          n_tx    = 0;
   logic [10:0] last_id = 11'h000;
   initial begin
      rx_valid  = 1'b0;
      rx_cob_id = 11'h000;
      rx_byte   = 8'h00;
   end
   // Idle lines carry the inverse so a stale frame never looks current.
   task automatic send(input logic [7:0] b);
      @(negedge clk);
      rx_valid  = 1'b1;
      rx_cob_id = COB_RX_BASE + 11'(node_id);
      rx_byte   = b;
      @(negedge clk);
      rx_valid  = 1'b0;
      rx_cob_id = ~rx_cob_id;
      rx_byte   = ~b;
   endtask
   always @(posedge clk) begin
      if (tx_request_q === 1'b1) begin
         n_tx++;
         last_id = tx_cob_id_q;
      end
   end
endmodule

// ===== sim/dioc_top_tb.sv
/* Testbench of the channel logic: object port, frames, events, pulses.
   Assumes MS_CYCLES 4 and FILT_CYCLES 2 to keep the run short. */
`timescale 1ns/1ns
module dioc_top_tb;
   import dioc_pkg::*;
   logic        clk, resetn, error_event;
   logic        obj_wr, obj_rd, rx_valid, tx_request_q;
   logic [15:0] in_pins, obj_index;
   logic [7:0]  obj_subindex, obj_wdata, rx_byte, obj_rdata_q;
   logic [6:0]  node_id, m_node;
   logic [7:0]  input_byte_low, input_byte_high, output_byte;
   logic [10:0] rx_cob_id, tx_cob_id_q;
   logic        obj_ack_q, obj_err_q;
   int          n_mismatch = 0, n_checks = 0;
   always #20 clk = ~clk;
   dioc_top #(.MS_CYCLES(4), .FILT_CYCLES(2)) i_dut (.clk(clk), .resetn(resetn),
      .in_pins(in_pins), .node_id(node_id), .rx_valid(rx_valid), .rx_cob_id(rx_cob_id),
      .rx_byte(rx_byte), .error_event(error_event), .obj_wr(obj_wr), .obj_rd(obj_rd),
      .obj_index(obj_index), .obj_subindex(obj_subindex), .obj_wdata(obj_wdata),
      .obj_rdata_q(obj_rdata_q), .obj_ack_q(obj_ack_q), .obj_err_q(obj_err_q),
      .tx_request_q(tx_request_q), .tx_cob_id_q(tx_cob_id_q),
      .input_byte_low(input_byte_low), .input_byte_high(input_byte_high),
      .output_byte(output_byte));
   dioc_master_model i_master (.clk(clk), .node_id(m_node), .tx_request_q(tx_request_q),
      .tx_cob_id_q(tx_cob_id_q), .rx_valid(rx_valid), .rx_cob_id(rx_cob_id),
      .rx_byte(rx_byte));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Ack comes exactly one cycle after the request, so no wait is needed.
   task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                      input logic [7:0] d, input logic [8:0] exp);
      @(negedge clk);
      obj_wr       = w;
      obj_rd       = ~w;
      obj_index    = i;
      obj_subindex = s;
      obj_wdata    = d;
      @(negedge clk);
      chk(obj_ack_q, 16'h0001);
      if (!w) chk({obj_err_q, obj_rdata_q}, exp);
      else chk(obj_err_q, 16'(exp[8]));
      obj_wr    = 1'b0;
      obj_rd    = 1'b0;
      obj_wdata = ~d;
   endtask
   task automatic ev(input logic [15:0] p, input int n);
      int old;
      old = i_master.n_tx;
      @(negedge clk);
      in_pins = p;
      repeat (14) @(negedge clk);
      chk(16'(i_master.n_tx - old), 16'(n));
   endtask
   task automatic gl(input int w, input int n);
      int old;
      old = i_master.n_tx;
      @(negedge clk);
      in_pins[8] = 1'b1;
      repeat (w) @(negedge clk);
      in_pins[8] = 1'b0;
      repeat (14) @(negedge clk);
      chk(16'(i_master.n_tx - old), 16'(n));
   endtask
   task automatic pc(input int exp);
      int c;
      c = 0;
      repeat (24) begin
         if (output_byte[4] === 1'b1) c++;
         @(negedge clk);
      end
      chk(16'(c), 16'(exp));
   endtask
   task automatic t_reset;
      acc(0, IDX_UPDATE_GATE, SUB_LOW, 8'h00, 9'h0FF);
      acc(0, IDX_PULSE_LEN, SUB_LOW, 8'h00, 9'h001);
      acc(0, IDX_ANY_MASK, SUB_HIGH, 8'h00, 9'h0FF);
      acc(0, IDX_RISE_MASK, SUB_LOW, 8'h00, 9'h000);
      acc(0, IDX_FALL_MASK, SUB_HIGH, 8'h00, 9'h000);
      acc(0, IDX_ERR_MODE, SUB_LOW, 8'h00, 9'h000);
      acc(0, IDX_ERR_VALUE, SUB_LOW, 8'h00, 9'h000);
      acc(0, IDX_GLOBAL_EN, SUB_VAR, 8'h00, 9'h000);
      acc(0, 16'h1234, SUB_LOW, 8'h00, 9'h100);
      acc(1, IDX_INPUTS, SUB_LOW, 8'h55, 9'h100);
      acc(1, IDX_OUTPUTS, SUB_LOW, 8'h55, 9'h100);
   endtask
   task automatic t_outputs;
      acc(1, IDX_UPDATE_GATE, SUB_LOW, 8'hFE, 9'h000);
      i_master.send(8'h03);
      chk(output_byte, 8'h02);
      i_master.send(8'h22);
      repeat (20) @(negedge clk);
      chk(output_byte, 8'h22);
      m_node = 7'h06;
      i_master.send(8'h00);
      chk(output_byte, 8'h22);
      node_id = 7'h06;
      i_master.send(8'h00);
      chk(output_byte, 8'h00);
      chk(tx_cob_id_q, COB_TX_BASE + 11'h006);
      node_id = 7'h05;
      m_node  = 7'h05;
      i_master.send(8'h22);
   endtask
   task automatic t_error;
      acc(1, IDX_ERR_MODE, SUB_LOW, 8'h06, 9'h000);
      acc(1, IDX_ERR_VALUE, SUB_LOW, 8'h04, 9'h000);
      @(negedge clk);
      error_event = 1'b1;
      @(negedge clk);
      error_event = 1'b0;
      chk(output_byte, 8'h24);
   endtask
   task automatic t_events;
      ev(16'h0001, 0);
      ev(16'h0000, 0);
      // One trigger type per line: clear any-change before rise/fall.
      acc(1, IDX_ANY_MASK, SUB_LOW, 8'h00, 9'h000);
      acc(1, IDX_ANY_MASK, SUB_HIGH, 8'h00, 9'h000);
      acc(1, IDX_RISE_MASK, SUB_LOW, 8'h01, 9'h000);
      acc(1, IDX_FALL_MASK, SUB_LOW, 8'h02, 9'h000);
      acc(1, IDX_GLOBAL_EN, SUB_VAR, 8'h01, 9'h000);
      acc(0, IDX_FALL_MASK, SUB_LOW, 8'h00, 9'h002);
      ev(16'h0001, 1);
      chk(input_byte_low, 8'h01);
      chk(i_master.last_id, COB_TX_BASE + 11'h005);
      ev(16'h0000, 0);
      ev(16'h0002, 0);
      ev(16'h0000, 1);
      ev(16'h0100, 0);
      chk(input_byte_high, 8'h01);
      acc(1, IDX_ANY_MASK, SUB_HIGH, 8'h01, 9'h000);
      ev(16'h0000, 1);
      gl(2, 2);
      acc(1, IDX_FILTER_EN, SUB_HIGH, 8'h01, 9'h000);
      gl(2, 0);
      gl(6, 2);
   endtask
   task automatic t_pulse;
      acc(1, IDX_PULSE_EN, SUB_LOW, 8'h10, 9'h000);
      acc(1, IDX_PULSE_LEN, 8'h05, 8'h02, 9'h000);
      i_master.send(8'h10);
      pc(8);
      acc(1, IDX_RETRIG_EN, SUB_LOW, 8'h10, 9'h000);
      i_master.send(8'h10);
      repeat (4) @(negedge clk);
      i_master.send(8'h10);
      pc(8);
      acc(1, IDX_EARLY_OFF, SUB_LOW, 8'h10, 9'h000);
      i_master.send(8'h10);
      i_master.send(8'h00);
      @(negedge clk);
      chk(output_byte[4], 16'h0000);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #2000000;
      n_mismatch++;
      summarize();
   end
   initial begin
      clk          = 1'b0;
      resetn       = 1'b0;
      error_event  = 1'b0;
      obj_wr       = 1'b0;
      obj_rd       = 1'b0;
      in_pins      = 16'h0000;
      obj_index    = 16'h0000;
      obj_subindex = 8'h00;
      obj_wdata    = 8'h00;
      node_id      = 7'h05;
      m_node       = 7'h05;
      repeat (8) @(posedge clk);
      @(negedge clk);
      resetn = 1'b1;
      t_reset();
      t_outputs();
      t_error();
      t_events();
      t_pulse();
      summarize();
   end
endmodule
